// >>> rmcl_pkg.sv
// Package for the RS-232 modem-control block: register map, fields, modes.
// Assumes a 32-bit classic Wishbone slave with word-aligned registers.
package rmcl_pkg;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] RMCL_CTRL_OFS = 8'h00;
  localparam logic [7:0] RMCL_OVR_OFS = 8'h04;
  localparam logic [7:0] RMCL_STAT_OFS = 8'h08;
  localparam logic [7:0] RMCL_OCC_OFS = 8'h0C;

  // ----------------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------------
  localparam int RMCL_CTRL_CARRIER = 0;
  localparam int RMCL_CTRL_FLOW = 1;
  localparam int RMCL_CTRL_HALF = 2;
  localparam int RMCL_CTRL_MODEM = 3;
  localparam int RMCL_CTRL_PROTO_LO = 4;
  localparam int RMCL_CTRL_COMM_EN = 6;
  localparam int RMCL_CTRL_W = 7;
  localparam logic [6:0] RMCL_CTRL_RST = 7'h00;

  // Override register fields
  localparam int RMCL_OVR_RTS = 0;
  localparam int RMCL_OVR_DTR = 1;
  localparam logic [1:0] RMCL_OVR_RST = 2'h3;

  // Status word fields
  localparam int RMCL_ST_RTS = 0;
  localparam int RMCL_ST_DSR = 1;
  localparam int RMCL_ST_DTR = 2;
  localparam int RMCL_ST_DCD = 3;
  localparam int RMCL_ST_CTS = 4;
  localparam int RMCL_ST_RI = 5;

  // Protocol modes
  typedef enum logic [1:0] {
    RMCL_PROTO_NONPROC = 2'h0,
    RMCL_PROTO_CMD = 2'h1,
    RMCL_PROTO_BIDIR = 2'h2,
    RMCL_PROTO_PREDEF = 2'h3
  } rmcl_proto_t;

  // Override latency: up to 20 ms allowed; applied in one cycle here
  localparam int RMCL_OVR_LAG_MS = 20;

  // Modem inputs grouped
  typedef struct packed {
    logic dcd;
    logic dsr;
    logic cts;
    logic ri;
  } rmcl_modem_in_t;

  // Wishbone request
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } rmcl_wb_req_t;

endpackage

// >>> rmcl_modem_ctrl.sv
// Modem-control and flow gating for one RS-232 channel.
// Assumes pins synchronous-capable inputs and an engine that honours txAllow.
// Notes on behaviour
// - full duplex with carrier check needs DCD
// - DCD loss mid-transfer reinitialises transmit sequence
// - carrier check off ignores DCD
// - non-procedure flow control: DTR follows free storage
// - no DTR/DSR control keeps DTR asserted
// - command and bidirectional modes assert DTR when enabled
// - flow control: DSR low suspends transmission
// - no flow control ignores DSR
// - full duplex RTS follows module ready flag
// - half duplex RTS only while transmitting
// - full receive storage never drops RTS
// - CTS low withholds transmission always
// - RI sampled for ring monitoring
// - status word RTS DSR DTR DCD CTS RI
// - overrides within 20 ms, ignored when owned
//
// Decided for this implementation: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module rmcl_modem_ctrl
  import rmcl_pkg::*;
#(
  parameter int OCC_W = 10,
  parameter logic [9:0] LOW_WATER = 10'h010,
  parameter logic [9:0] HIGH_WATER = 10'h040
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [3:0] wbSel,
  input wire logic [7:0] wbAdr,
  input wire logic [31:0] wbDatIn,
  output logic [31:0] wbDatOut,
  output logic wbAck,
  input wire logic [OCC_W-1:0] rxFree,
  input wire logic module_ready_flag,
  input wire logic txBusy,
  input wire logic xferActive,
  input wire logic carrier_detect_in,
  input wire logic dsrIn,
  input wire logic ctsIn,
  input wire logic riIn,
  output logic request_to_send_out,
  output logic dtrOut,
  output logic txAllow,
  output logic rxAllow,
  output logic seqReinit
);

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  rmcl_modem_in_t syncA_reg;
  rmcl_modem_in_t syncB_reg;

  // Pins move freely against mclk and the first stage may go metastable,
  // so only the second stage feeds the gating, the flops and the status word
  // Two-stage capture of the modem inputs
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      syncA_reg <= '0;
      syncB_reg <= '0;
    end else begin
      syncA_reg <= '{dcd: carrier_detect_in, dsr: dsrIn, cts: ctsIn, ri: riIn};
      syncB_reg <= syncA_reg;
    end
  end

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  logic [RMCL_CTRL_W-1:0] ctrl_reg;
  logic [1:0] ovr_reg;
  logic wbHit;
  logic wbWrite;

  assign wbHit = wbCyc && wbStb && !wbAck;
  assign wbWrite = wbHit && wbWe && wbSel[0];

  // Writes land on the edge that takes the request; the ack follows.
  // Byte lane 0 off, read-only slots and unmapped slots drop the write,
  // so a stray store cannot move the lines
  // Control and override writes
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= RMCL_CTRL_RST;
      ovr_reg <= RMCL_OVR_RST;
    end else if (wbWrite && wbAdr == RMCL_CTRL_OFS) begin
      ctrl_reg <= wbDatIn[RMCL_CTRL_W-1:0];
    end else if (wbWrite && wbAdr == RMCL_OVR_OFS) begin
      ovr_reg <= wbDatIn[1:0];
    end
  end

  // Decoded configuration
  logic carrierChk;
  logic flowCtl;
  logic halfDup;
  logic modemOwn;
  logic commEn;
  rmcl_proto_t proto;

  assign carrierChk = ctrl_reg[RMCL_CTRL_CARRIER];
  assign flowCtl = ctrl_reg[RMCL_CTRL_FLOW];
  assign halfDup = ctrl_reg[RMCL_CTRL_HALF];
  assign modemOwn = ctrl_reg[RMCL_CTRL_MODEM];
  assign commEn = ctrl_reg[RMCL_CTRL_COMM_EN];
  assign proto = rmcl_proto_t'(ctrl_reg[RMCL_CTRL_PROTO_LO +: 2]);

  // ----------------------------------------------------------------------
  // DTR control
  // ----------------------------------------------------------------------
  logic roomFlag_reg;
  logic dtr_next;
  logic dtr_reg;

  // One threshold would make DTR chatter as the host drains entry by
  // entry; the gap between the two marks keeps the partner stopped
  // until real room has come back
  // Hysteresis on receive storage room
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      roomFlag_reg <= 1'b1;
    end else if (rxFree <= LOW_WATER) begin
      roomFlag_reg <= 1'b0;
    end else if (rxFree >= HIGH_WATER) begin
      roomFlag_reg <= 1'b1;
    end
  end

  // Priority: protocol modes that own DTR, then flow control, then
  // modem ownership, and only then the software override; the override
  // therefore never fights a mode that drives the line itself
  // DTR source selection
  always_comb begin
    if (proto == RMCL_PROTO_CMD || proto == RMCL_PROTO_BIDIR) begin
      dtr_next = commEn;
    end else if (flowCtl && proto == RMCL_PROTO_NONPROC) begin
      dtr_next = roomFlag_reg;
    end else if (flowCtl || modemOwn) begin
      dtr_next = 1'b1;
    end else begin
      dtr_next = ovr_reg[RMCL_OVR_DTR];
    end
    if (!flowCtl && !modemOwn && proto != RMCL_PROTO_CMD && proto != RMCL_PROTO_BIDIR
        && !ovr_reg[RMCL_OVR_DTR]) begin
      dtr_next = 1'b0;
    end else if (!flowCtl && !modemOwn && proto != RMCL_PROTO_CMD
        && proto != RMCL_PROTO_BIDIR) begin
      dtr_next = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // RTS control
  // ----------------------------------------------------------------------
  logic rts_next;
  logic rts_reg;

  // RTS is never a receive throttle: a full store must not hide the
  // module from the partner, so occupancy plays no part here
  // RTS source selection, never from receive occupancy
  always_comb begin
    if (halfDup) begin
      rts_next = txBusy;
    end else if (modemOwn) begin
      rts_next = module_ready_flag;
    end else begin
      rts_next = module_ready_flag && ovr_reg[RMCL_OVR_RTS];
    end
  end

  // Registering both lines keeps select glitches off the pins
  // Output flops, low during reset
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dtr_reg <= 1'b0;
      rts_reg <= 1'b0;
    end else begin
      dtr_reg <= dtr_next;
      rts_reg <= rts_next;
    end
  end

  assign dtrOut = dtr_reg;
  assign request_to_send_out = rts_reg;

  // ----------------------------------------------------------------------
  // Transfer gating
  // ----------------------------------------------------------------------
  logic carrierOk;
  logic dcdPrev_reg;

  // Half duplex leaves carrier handling to the engine itself
  assign carrierOk = !carrierChk || halfDup || syncB_reg.dcd;
  assign rxAllow = carrierOk;
  assign txAllow = carrierOk && syncB_reg.cts
                   && (!flowCtl || syncB_reg.dsr);

  // Edge taken on the synchronised level with no debounce, so a bouncing pin
  // yields one pulse for every fall of that level
  // DCD fall during a transfer restarts the sequence
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dcdPrev_reg <= 1'b0;
      seqReinit <= 1'b0;
    end else begin
      dcdPrev_reg <= syncB_reg.dcd;
      seqReinit <= carrierChk && !halfDup && xferActive
                   && dcdPrev_reg && !syncB_reg.dcd;
    end
  end

  // ----------------------------------------------------------------------
  // Wishbone read and acknowledge
  // ----------------------------------------------------------------------
  logic [5:0] statWord;

  // Live levels as the logic sees them, not the raw pins
  assign statWord = {syncB_reg.ri, syncB_reg.cts, syncB_reg.dcd, dtr_reg,
                     syncB_reg.dsr, rts_reg};

  // The ack blocks a take only in its own cycle, so a held
  // strobe is taken again and answered every second cycle; read data stands until the
  // next read
  // Single-wait acknowledge with registered read data
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wbAck <= 1'b0;
      wbDatOut <= 32'h0000_0000;
    end else begin
      wbAck <= wbHit;
      if (wbHit && !wbWe) begin
        unique case (wbAdr)
          RMCL_CTRL_OFS: wbDatOut <= {25'h0, ctrl_reg};
          RMCL_OVR_OFS: wbDatOut <= {30'h0, ovr_reg};
          RMCL_STAT_OFS: wbDatOut <= {26'h0, statWord};
          RMCL_OCC_OFS: wbDatOut <= {{(32-OCC_W){1'b0}}, rxFree};
          default: wbDatOut <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  // Checks on rule-bound behaviour; a write on the sampling edge may
  // move the configuration, so checks spanning an edge leave it out, all but a_dtr_low
  sequence dcdFall;
    $fell(syncB_reg.dcd) && carrierChk && !halfDup && xferActive;
  endsequence

  // Status read strobe shared by the status checks
  sequence statRead;
    wbHit && !wbWe && wbAdr == RMCL_STAT_OFS;
  endsequence

  // Carrier loss mid-transfer restarts the sequence next cycle
  a_dcd_reinit: assert property (@(posedge mclk) disable iff (rst)
    dcdFall |=> seqReinit) else $error("no reinit on DCD loss");

  // A restart pulse only follows a checked transfer
  a_reinit_cause: assert property (@(posedge mclk) disable iff (rst)
    seqReinit |-> $past(xferActive) && $past(carrierChk))
    else $error("reinit without transfer");

  // No carrier, no traffic either way
  a_carrier_gate: assert property (@(posedge mclk) disable iff (rst)
    carrierChk && !halfDup && !syncB_reg.dcd |-> !txAllow && !rxAllow)
    else $error("transfer without carrier");

  // Check off: receive never waits for carrier
  a_carrier_off: assert property (@(posedge mclk) disable iff (rst)
    !carrierChk |-> rxAllow) else $error("DCD gated with check off");

  // CTS low stops sending in every mode
  a_cts_block: assert property (@(posedge mclk) disable iff (rst)
    !syncB_reg.cts |-> !txAllow) else $error("send with CTS low");

  // Flow control: DSR low stops sending
  a_dsr_block: assert property (@(posedge mclk) disable iff (rst)
    flowCtl && !syncB_reg.dsr |-> !txAllow) else $error("send with DSR low");

  // Without flow control DSR has no say
  a_dsr_ignore: assert property (@(posedge mclk) disable iff (rst)
    !flowCtl && carrierOk && syncB_reg.cts |-> txAllow)
    else $error("DSR gated without flow control");

  // Half duplex: RTS follows the transmitter one cycle late
  a_half_rts: assert property (@(posedge mclk) disable iff (rst)
    halfDup && $stable(halfDup) |-> request_to_send_out == $past(txBusy))
    else $error("half duplex RTS wrong");

  // Full duplex: ready and an open override raise RTS, storage aside
  a_full_rts: assert property (@(posedge mclk) disable iff (rst)
    !wbWrite && !halfDup && module_ready_flag && (modemOwn || ovr_reg[RMCL_OVR_RTS])
    |=> request_to_send_out) else $error("full duplex RTS dropped");

  // Software override lowers RTS when nothing else owns it
  a_ovr_rts: assert property (@(posedge mclk) disable iff (rst)
    !wbWrite && !halfDup && !modemOwn && !ovr_reg[RMCL_OVR_RTS]
    |=> !request_to_send_out) else $error("RTS override ignored");

  // Storage at the low mark drops DTR two cycles on
  a_dtr_low: assert property (@(posedge mclk) disable iff (rst)
    flowCtl && proto == RMCL_PROTO_NONPROC && rxFree <= LOW_WATER
    |=> ##1 !dtrOut) else $error("DTR kept with storage low");

  // No flow control: DTR up while the override allows it
  a_dtr_free: assert property (@(posedge mclk) disable iff (rst)
    !wbWrite && !flowCtl && !modemOwn && ovr_reg[RMCL_OVR_DTR]
    && (proto == RMCL_PROTO_NONPROC || proto == RMCL_PROTO_PREDEF)
    |=> dtrOut) else $error("DTR dropped without flow control");

  // Override lowers DTR only when no mode owns it
  a_ovr_dtr: assert property (@(posedge mclk) disable iff (rst)
    !wbWrite && !flowCtl && !modemOwn && !ovr_reg[RMCL_OVR_DTR]
    && (proto == RMCL_PROTO_NONPROC || proto == RMCL_PROTO_PREDEF)
    |=> !dtrOut) else $error("DTR override ignored");

  // Command and bidirectional modes raise DTR with the enable
  a_dtr_comm: assert property (@(posedge mclk) disable iff (rst)
    !wbWrite && (proto == RMCL_PROTO_CMD || proto == RMCL_PROTO_BIDIR)
    |=> dtrOut == $past(commEn)) else $error("DTR not following enable");

  // Status word carries live DTR
  a_stat_dtr: assert property (@(posedge mclk) disable iff (rst)
    statRead |=> wbDatOut[RMCL_ST_DTR] == $past(dtr_reg) && wbAck)
    else $error("status word wrong");

  // Status word carries the sampled ring line, upper bits clear
  a_stat_ri: assert property (@(posedge mclk) disable iff (rst)
    statRead |=> wbDatOut[RMCL_ST_RI] == $past(syncB_reg.ri) && wbDatOut[31:6] == 26'h0)
    else $error("status ring bit wrong");

  // Every taken request is answered on the next edge
  a_ack_answer: assert property (@(posedge mclk) disable iff (rst)
    wbHit |=> wbAck) else $error("request not answered");

  // The answer lasts one cycle only
  a_ack_pulse: assert property (@(posedge mclk) disable iff (rst)
    wbAck |=> !wbAck) else $error("acknowledge held too long");

endmodule
`default_nettype wire

// >>> rmcl_modem_model.sv
// Behavioural far-end modem or terminal driving DCD, DSR, CTS and RI.
// Assumes the bench sets the wanted levels and the able flag.
`timescale 1ns/1ps
`default_nettype none
module rmcl_modem_model
  import rmcl_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic able,
  input wire logic [3:0] want,
  output var rmcl_modem_in_t lines
);
  // Line drive, DSR and CTS forced low while not able to accept
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      lines <= '0;
    end else begin
      lines <= {want[3], want[2] & able, want[1] & able, want[0]};
    end
  end
endmodule
`default_nettype wire

// >>> rmcl_modem_ctrl_tb.sv
// Self-checking bench for the modem-control block.
// Assumes the partner model and a classic Wishbone master task.
`timescale 1ns/1ps
`default_nettype none
module rmcl_modem_ctrl_tb
  import rmcl_pkg::*;
();
  logic mclk = 0, rst = 1, cyc = 0, stb = 0, we = 0, rdy = 0, busy = 0, xfer = 0;
  logic able = 1;
  logic [3:0] sel = 4'h0, want = 4'h0;
  logic [7:0] adr = 8'h00;
  logic [31:0] datIn = 32'h0, datOut, rdv;
  logic [9:0] rxFree = 10'h100;
  logic ack, rts, dtr, txA, rxA, reinit;
  logic [16:0] r;
  rmcl_modem_in_t lines;
  int mismatches = 0, tests_run = 0, n;
  // Row: ctrl, rdy busy dcd dsr cts ri, expected tx rx rts dtr
  logic [16:0] rows [12] = '{
    {7'h41, 6'h2F, 4'hF}, {7'h41, 6'h27, 4'h3}, {7'h40, 6'h27, 4'hF},
    {7'h42, 6'h2B, 4'h7}, {7'h40, 6'h2B, 4'hF}, {7'h40, 6'h2D, 4'h7},
    {7'h42, 6'h2D, 4'h7}, {7'h40, 6'h0E, 4'hD}, {7'h50, 6'h2F, 4'hF},
    {7'h60, 6'h2F, 4'hF}, {7'h44, 6'h2F, 4'hD}, {7'h45, 6'h37, 4'hF}};

  rmcl_modem_model partner (.mclk(mclk), .rst(rst), .able(able), .want(want), .lines(lines));
  rmcl_modem_ctrl dut (.mclk(mclk), .rst(rst), .wbCyc(cyc), .wbStb(stb), .wbWe(we),
    .wbSel(sel), .wbAdr(adr), .wbDatIn(datIn), .wbDatOut(datOut), .wbAck(ack),
    .rxFree(rxFree), .module_ready_flag(rdy), .txBusy(busy), .xferActive(xfer),
    .carrier_detect_in(lines.dcd), .dsrIn(lines.dsr), .ctsIn(lines.cts), .riIn(lines.ri),
    .request_to_send_out(rts), .dtrOut(dtr), .txAllow(txA), .rxAllow(rxA),
    .seqReinit(reinit));

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic final_report();
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // One classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    datIn <= d;
    sel <= 4'hF;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      $display("unexpected at %0t: no ack", $time);
      mismatches++;
      final_report();
    end
    rdv = datOut;
    cyc <= 0;
    stb <= 0;
    we <= 0;
  endtask
  task automatic settle();
    repeat (5) @(negedge mclk);
  endtask
  function automatic logic [31:0] pins();
    return {28'h0, txA, rxA, rts, dtr};
  endfunction

  // Clock and hang guard
  initial forever #12.5 mclk = ~mclk;
  initial begin
    #500000;
    $display("unexpected at %0t: run hung", $time);
    mismatches++;
    final_report();
  end

  // Main sequence
  initial begin
    repeat (2) @(negedge mclk);
    chk({28'h0, rts, dtr, reinit, ack}, 32'h0, "in reset");
    repeat (2) @(posedge mclk);
    rst <= 0;
    wb(0, RMCL_CTRL_OFS, 32'h0);
    chk(rdv, 32'h0, "ctrl reset");
    wb(0, RMCL_OVR_OFS, 32'h0);
    chk(rdv, 32'h3, "ovr reset");
    wb(0, 8'h10, 32'h0);
    chk(rdv, 32'h0, "unmapped");
    $display("reset test done");
    for (int i = 0; i < 12; i++) begin
      r = rows[i];
      wb(1, RMCL_CTRL_OFS, {25'h0, r[16:10]});
      rdy <= r[9];
      busy <= r[8];
      want <= r[7:4];
      settle();
      chk(pins(), {28'h0, r[3:0]}, "pins");
      wb(0, RMCL_STAT_OFS, 32'h0);
      chk(rdv, {26'h0, r[4], r[5], r[7], r[0], r[6], r[1]}, "status");
      $display("row %0d done", i);
    end
    wb(1, RMCL_CTRL_OFS, 32'h42);
    rxFree <= 10'h000;
    settle();
    chk({30'h0, rts, dtr}, 32'h2, "storage full");
    rxFree <= 10'h030;
    settle();
    chk({31'h0, dtr}, 32'h0, "below high water");
    wb(0, RMCL_OCC_OFS, 32'h0);
    chk(rdv, 32'h30, "occupancy");
    rxFree <= 10'h040;
    settle();
    chk({31'h0, dtr}, 32'h1, "drained");
    $display("flow test done");
    wb(1, RMCL_OVR_OFS, 32'h0);
    settle();
    chk({30'h0, rts, dtr}, 32'h1, "dtr owned");
    wb(1, RMCL_CTRL_OFS, 32'h40);
    settle();
    chk({30'h0, rts, dtr}, 32'h0, "overrides");
    wb(1, RMCL_OVR_OFS, 32'h3);
    $display("override test done");
    wb(1, RMCL_CTRL_OFS, 32'h41);
    want <= 4'hF;
    xfer <= 1;
    settle();
    @(posedge mclk);
    want <= 4'h7;
    n = 0;
    while (reinit !== 1'b1 && n < 10) begin
      @(negedge mclk);
      n++;
    end
    chk({31'h0, reinit}, 32'h1, "reinit pulse");
    chk({31'h0, txA}, 32'h0, "carrier lost");
    $display("carrier test done");
    @(posedge mclk);
    rst <= 1;
    xfer <= 0;
    repeat (2) @(negedge mclk);
    chk({28'h0, rts, dtr, reinit, ack}, 32'h0, "mid-run reset");
    @(posedge mclk);
    rst <= 0;
    wb(0, RMCL_OVR_OFS, 32'h0);
    chk(rdv, 32'h3, "ovr after reset");
    able <= 0;
    want <= 4'hF;
    settle();
    chk({30'h0, txA, rxA}, 32'h1, "partner busy");
    wb(0, RMCL_STAT_OFS, 32'h0);
    chk(rdv, 32'h2D, "status partner busy");
    able <= 1;
    settle();
    chk({30'h0, txA, rxA}, 32'h3, "partner able");
    $display("reset and partner test done");
    final_report();
  end
endmodule
`default_nettype wire
